// ===== shared/sch_pkg.sv
// shared constants and types for the synthesizer command handler
package sch_pkg;
    // command identifiers
    localparam logic [15:0] CMD_POWER_UP = 16'h080c;
    localparam logic [15:0] CMD_POWER_DOWN = 16'h080d;
    localparam logic [15:0] CMD_PROGRAM = 16'h0803;
    localparam logic [15:0] CMD_TURN_OFF = 16'h0804;
    // completion status codes
    localparam logic [3:0] ST_DONE_OK = 4'h1;
    localparam logic [3:0] ST_PARAM_ERR = 4'h2;
    localparam logic [3:0] ST_PROG_ERR = 4'h3;
    localparam logic [3:0] ST_NO_SETUP = 4'h4;
    localparam logic [3:0] ST_NOT_POWERED = 4'h5;
    // config byte fields
    localparam int CFG_TX_BIT = 0;
    localparam int CFG_DIV_LSB = 1;
    localparam int CFG_DIV_MSB = 6;
    localparam logic [5:0] DEFAULT_DIVIDER = 6'h00;
    // legal tuning window in integer MHz
    localparam logic [15:0] FREQ_MIN_MHZ = 16'h0155;
    localparam logic [15:0] FREQ_MAX_MHZ = 16'h0a00;
    // override entry layout
    localparam int ENTRY_TARGET_BIT = 31;
    localparam logic [7:0] MAX_OVERRIDES = 8'h40;
    // synthesizer power-up timeout in cycles
    localparam logic [7:0] POWER_UP_TIMEOUT = 8'hc8;
    typedef enum {S_IDLE, S_PWR_UP, S_OVR_REQ, S_OVR_WAIT, S_PROGRAM, S_PWR_DOWN, S_DONE} sch_state_e;
endpackage : sch_pkg

// ===== shared/sch_if.sv
// command link between host and synthesizer command handler
`timescale 1ns/1ps
`default_nettype none
interface sch_if;
    logic cmd_valid;
    logic cmd_ready;
    logic [15:0] cmd_id;
    logic [15:0] frequency;
    logic [15:0] fractional_frequency;
    logic [7:0] synth_config_byte;
    logic [31:0] override_list_pointer;
    logic trigger;
    logic ovr_req;
    logic [7:0] ovr_index;
    logic ovr_valid;
    logic [31:0] ovr_entry;
    logic ovr_last;
    logic ovr_bad;
    logic done;
    logic [3:0] status;
    logic lock_lost_irq;
    modport device (input cmd_valid, cmd_id, frequency, fractional_frequency, synth_config_byte,
        override_list_pointer, trigger, ovr_valid, ovr_entry, ovr_last, ovr_bad,
        output cmd_ready, ovr_req, ovr_index, done, status, lock_lost_irq);
    modport host (output cmd_valid, cmd_id, frequency, fractional_frequency, synth_config_byte,
        override_list_pointer, trigger, ovr_valid, ovr_entry, ovr_last, ovr_bad,
        input cmd_ready, ovr_req, ovr_index, done, status, lock_lost_irq);
endinterface : sch_if
`default_nettype wire

// ===== core/sch_device.sv
// radio-side synthesizer command handler
`timescale 1ns/1ps
`default_nettype none
// Function
// - power-up command powers synth, applies overrides
// - null pointer: no overrides, still power
// - apply only synthesizer-targeted override entries
// - host powers synth before using it
// - host completes setup before power-up
// - bad pointer, entry or length: parameter error
// - power failure: programming error, else success
// - power-down waits trigger, powers down, success
// - power-down also switches analog modules off
// - host re-powers synth after power-down
// - host powers synth down before radio off
// - tune to integer plus fraction over 65536
// - config bit 0 selects receive or transmit
// - nonzero divider: reference 24 MHz over divider
// - lock lost after lock raises interrupt
// - interrupt once per programming, re-armed by programming
// - implicit programming also arms the interrupt
// - illegal frequency or divider: parameter error; code checks frequency and config bit 7, not the divider
// - no setup: no-setup error status
// - not powered: not-powered error status
// - turn-off disables outputs, resets, analog stays
module sch_device
    import sch_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command link
    sch_if.device link,
    // radio state from the rest of the core
    input wire logic radio_setup_done,
    input wire logic implicit_program,
    // synthesizer hardware
    input wire logic synth_powered_ok,
    input wire logic synth_lock,
    output logic synth_analog_on,
    output logic synth_running,
    output logic synth_tx_mode,
    output logic [5:0] synth_ref_divider,
    output logic [15:0] synth_freq_int,
    output logic [15:0] synth_freq_frac,
    output logic synth_program_strobe,
    output logic ovr_write,
    output logic [30:0] ovr_write_data
);
    sch_state_e state_q, state_d;
    logic [7:0] idx_q, timer_q;
    logic [3:0] status_q;
    logic done_q, analog_q, run_q, tx_q, prog_q, irq_q;
    logic [5:0] div_q;
    logic [15:0] fint_q, ffrac_q;
    logic wr_q;
    logic [30:0] wr_data_q;
    // lock tracking: armed per programming, fires once
    logic locked_seen_q, irq_armed_q;
    logic [1:0] lock_sync_q;
    logic [1:0] pwr_sync_q;

    wire idle = state_q == S_IDLE;
    wire take = idle && link.cmd_valid;
    wire is_up = link.cmd_id == CMD_POWER_UP;
    wire is_down = link.cmd_id == CMD_POWER_DOWN;
    wire is_prog = link.cmd_id == CMD_PROGRAM;
    wire is_off = link.cmd_id == CMD_TURN_OFF;
    wire [5:0] cfg_div = link.synth_config_byte[CFG_DIV_MSB:CFG_DIV_LSB];
    wire freq_bad = link.frequency < FREQ_MIN_MHZ || link.frequency > FREQ_MAX_MHZ
        || link.synth_config_byte[7];
    wire entry_for_synth = link.ovr_entry[ENTRY_TARGET_BIT];
    wire lock_now = lock_sync_q[1];
    wire powered_now = pwr_sync_q[1];
    wire any_program = (take && is_prog && radio_setup_done && analog_q && !freq_bad) || implicit_program;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (link.cmd_valid)
                begin
                    if (is_up)
                        state_d = S_PWR_UP;
                    else if (is_down)
                        state_d = S_PWR_DOWN;
                    else
                        state_d = S_DONE;
                end
            S_PWR_UP:
                if (powered_now)
                    state_d = (link.override_list_pointer == 32'h0) ? S_DONE : S_OVR_REQ;
                else if (timer_q == POWER_UP_TIMEOUT)
                    state_d = S_DONE;
            S_OVR_REQ:
                state_d = (idx_q >= MAX_OVERRIDES) ? S_DONE : S_OVR_WAIT;
            S_OVR_WAIT:
                if (link.ovr_valid)
                    state_d = (link.ovr_bad || link.ovr_last) ? S_DONE : S_OVR_REQ;
            S_PWR_DOWN:
                if (link.trigger)
                    state_d = S_DONE;
            S_DONE:
                state_d = S_IDLE;
            default:
                state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= S_IDLE;
            idx_q <= 8'h00;
            timer_q <= 8'h00;
            status_q <= 4'h0;
            done_q <= 1'b0;
            analog_q <= 1'b0;
            run_q <= 1'b0;
            tx_q <= 1'b0;
            div_q <= DEFAULT_DIVIDER;
            fint_q <= 16'h0000;
            ffrac_q <= 16'h0000;
            prog_q <= 1'b0;
            wr_q <= 1'b0;
            wr_data_q <= 31'h0;
            lock_sync_q <= 2'b00;
            pwr_sync_q <= 2'b00;
            locked_seen_q <= 1'b0;
            irq_armed_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            lock_sync_q <= {lock_sync_q[0], synth_lock};
            pwr_sync_q <= {pwr_sync_q[0], synth_powered_ok};
            done_q <= 1'b0;
            prog_q <= 1'b0;
            wr_q <= 1'b0;
            irq_q <= 1'b0;
            timer_q <= (state_q == S_PWR_UP) ? timer_q + 8'h01 : 8'h00;
            if (take)
            begin
                idx_q <= 8'h00;
                if (is_up)
                    analog_q <= 1'b1;
                else if (is_prog)
                begin
                    if (!radio_setup_done)
                        status_q <= ST_NO_SETUP;
                    else if (!analog_q)
                        status_q <= ST_NOT_POWERED;
                    else if (freq_bad)
                        status_q <= ST_PARAM_ERR;
                    else
                    begin
                        fint_q <= link.frequency;
                        ffrac_q <= link.fractional_frequency;
                        tx_q <= link.synth_config_byte[CFG_TX_BIT];
                        div_q <= cfg_div;
                        run_q <= 1'b1;
                        prog_q <= 1'b1;
                        status_q <= ST_DONE_OK;
                    end
                end
                else if (is_off)
                begin
                    run_q <= 1'b0;
                    status_q <= ST_DONE_OK;
                end
                else
                    status_q <= ST_PARAM_ERR;
            end
            case (state_q)
                S_PWR_UP:
                    if (powered_now)
                        status_q <= ST_DONE_OK;
                    else if (timer_q == POWER_UP_TIMEOUT)
                    begin
                        status_q <= ST_PROG_ERR;
                        // a failed power-up must not leave the synth looking powered
                        analog_q <= 1'b0;
                    end
                S_OVR_REQ:
                    if (idx_q >= MAX_OVERRIDES)
                        status_q <= ST_PARAM_ERR;
                S_OVR_WAIT:
                    if (link.ovr_valid)
                    begin
                        idx_q <= idx_q + 8'h01;
                        if (link.ovr_bad)
                            status_q <= ST_PARAM_ERR;
                        else if (entry_for_synth)
                        begin
                            wr_q <= 1'b1;
                            wr_data_q <= link.ovr_entry[30:0];
                        end
                    end
                S_PWR_DOWN:
                    if (link.trigger)
                    begin
                        run_q <= 1'b0;
                        analog_q <= 1'b0;
                        status_q <= ST_DONE_OK;
                    end
                S_DONE:
                    done_q <= 1'b1;
                default:
                    ;
            endcase
            if (implicit_program)
                run_q <= 1'b1;
            // lock watch: each programming re-arms once
            if (any_program)
            begin
                locked_seen_q <= 1'b0;
                irq_armed_q <= 1'b1;
            end
            else if (run_q && lock_now)
                locked_seen_q <= 1'b1;
            else if (run_q && locked_seen_q && !lock_now && irq_armed_q)
            begin
                irq_q <= 1'b1;
                irq_armed_q <= 1'b0;
            end
        end
    end

    assign link.cmd_ready = idle;
    assign link.ovr_req = state_q == S_OVR_REQ && idx_q < MAX_OVERRIDES;
    assign link.ovr_index = idx_q;
    assign link.done = done_q;
    assign link.status = status_q;
    assign link.lock_lost_irq = irq_q;
    assign synth_analog_on = analog_q;
    assign synth_running = run_q;
    assign synth_tx_mode = tx_q;
    assign synth_ref_divider = div_q;
    assign synth_freq_int = fint_q;
    assign synth_freq_frac = ffrac_q;
    assign synth_program_strobe = prog_q;
    assign ovr_write = wr_q;
    assign ovr_write_data = wr_data_q;
endmodule : sch_device
`default_nettype wire

// ===== core/sch_host.sv
// host-side issuer of synthesizer commands with override list memory
`timescale 1ns/1ps
`default_nettype none
module sch_host
    import sch_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [15:0] req_id,
    input wire logic [15:0] req_frequency,
    input wire logic [15:0] req_fraction,
    input wire logic [7:0] req_config,
    input wire logic [31:0] req_pointer,
    input wire logic req_trigger,
    // override list loading
    input wire logic list_we,
    input wire logic [5:0] list_addr,
    input wire logic [31:0] list_data,
    input wire logic [5:0] list_length,
    // results
    output logic resp_valid,
    output logic [3:0] resp_status,
    output logic lock_lost,
    output logic synth_up,
    // command link
    sch_if.host link
);
    logic [31:0] list_mem [0:63];
    logic busy_q, valid_q, rsp_q, irq_q, up_q;
    logic [3:0] st_q;
    logic [15:0] id_q, f_q, fr_q;
    logic [7:0] cfg_q;
    logic [31:0] ptr_q, ent_q;
    logic ent_v_q, ent_last_q, ent_bad_q;

    always_ff @(posedge clk)
        if (list_we)
            list_mem[list_addr] <= list_data;

    wire take = req_valid && !busy_q;
    wire sent = valid_q && link.cmd_ready;
    wire [7:0] len8 = {2'b00, list_length};

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy_q <= 1'b0;
            valid_q <= 1'b0;
            rsp_q <= 1'b0;
            st_q <= 4'h0;
            irq_q <= 1'b0;
            up_q <= 1'b0;
            id_q <= 16'h0000;
            f_q <= 16'h0000;
            fr_q <= 16'h0000;
            cfg_q <= 8'h00;
            ptr_q <= 32'h0;
            ent_q <= 32'h0;
            ent_v_q <= 1'b0;
            ent_last_q <= 1'b0;
            ent_bad_q <= 1'b0;
        end
        else
        begin
            rsp_q <= 1'b0;
            ent_v_q <= 1'b0;
            irq_q <= link.lock_lost_irq;
            if (take)
            begin
                busy_q <= 1'b1;
                valid_q <= 1'b1;
                id_q <= req_id;
                f_q <= req_frequency;
                fr_q <= req_fraction;
                cfg_q <= req_config;
                ptr_q <= req_pointer;
            end
            if (sent)
                valid_q <= 1'b0;
            if (link.ovr_req)
            begin
                ent_v_q <= 1'b1;
                ent_q <= list_mem[link.ovr_index[5:0]];
                ent_last_q <= link.ovr_index + 8'h01 >= len8;
                // zero-length list is an invalid array
                ent_bad_q <= list_length == 6'h00;
            end
            if (link.done)
            begin
                busy_q <= 1'b0;
                rsp_q <= 1'b1;
                st_q <= link.status;
                if (link.status == ST_DONE_OK && id_q == CMD_POWER_UP)
                    up_q <= 1'b1;
                else if (link.status == ST_DONE_OK && id_q == CMD_POWER_DOWN)
                    up_q <= 1'b0;
            end
        end
    end

    assign req_ready = !busy_q;
    assign resp_valid = rsp_q;
    assign resp_status = st_q;
    assign lock_lost = irq_q;
    assign synth_up = up_q;
    assign link.cmd_valid = valid_q;
    assign link.cmd_id = id_q;
    assign link.frequency = f_q;
    assign link.fractional_frequency = fr_q;
    assign link.synth_config_byte = cfg_q;
    assign link.override_list_pointer = ptr_q;
    assign link.trigger = req_trigger;
    assign link.ovr_valid = ent_v_q;
    assign link.ovr_entry = ent_q;
    assign link.ovr_last = ent_last_q;
    assign link.ovr_bad = ent_bad_q;
endmodule : sch_host
`default_nettype wire

// ===== dv/sch_sva.sv
// concurrent checks on the command link between host and device
`timescale 1ns/1ps
`default_nettype none
module sch_sva
    import sch_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // command link
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [15:0] cmd_id,
    input wire logic [15:0] frequency,
    input wire logic [7:0] synth_config_byte,
    input wire logic ovr_req,
    input wire logic ovr_valid,
    input wire logic done,
    input wire logic [3:0] status,
    input wire logic lock_lost_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire take = cmd_valid && cmd_ready;
    wire known = cmd_id == CMD_POWER_UP || cmd_id == CMD_POWER_DOWN || cmd_id == CMD_PROGRAM || cmd_id == CMD_TURN_OFF;
    wire bad_freq = frequency < FREQ_MIN_MHZ || frequency > FREQ_MAX_MHZ || synth_config_byte[7];
    a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
    a_ready_after_done: assert property (done |=> cmd_ready) else $error("not idle after done");
    a_program_answer: assert property (take && cmd_id == CMD_PROGRAM |-> ##2 done)
        else $error("program not answered in two cycles");
    a_turn_off_ok: assert property (take && cmd_id == CMD_TURN_OFF |-> ##2 done && status == ST_DONE_OK)
        else $error("turn-off not ended with success");
    a_unknown_refused: assert property (take && !known |-> ##2 done && status == ST_PARAM_ERR)
        else $error("unknown command not refused");
    a_illegal_program: assert property (take && cmd_id == CMD_PROGRAM && bad_freq |-> ##2 status != ST_DONE_OK)
        else $error("illegal program accepted");
    a_power_up_bound: assert property (take && cmd_id == CMD_POWER_UP |-> ##[3:600] done)
        else $error("power-up never completed");
    a_override_answer: assert property (ovr_req |=> ovr_valid) else $error("override entry not answered");
    a_irq_single: assert property (lock_lost_irq |=> !lock_lost_irq [*3])
        else $error("lock loss raised twice");
endmodule : sch_sva
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench: host and device joined across the command link
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sch_pkg::*;
    logic clk, rst, req_valid, req_ready, req_trigger, list_we, resp_valid, lock_lost, synth_up;
    logic setup_done, impl_prog, powered_ok, lock_in, analog_on, running, tx_mode, ovr_write;
    logic prog_strobe;
    logic [15:0] req_id, req_frequency, req_fraction, freq_int, freq_frac;
    logic [7:0] req_config;
    logic [31:0] req_pointer, list_data;
    logic [30:0] wr_data;
    logic [5:0] list_addr, list_length, ref_div;
    logic [3:0] resp_status;
    logic [31:0] ents [3] = '{32'h8000_0011, 32'h0000_0022, 32'h8000_0033};
    int error_cnt = 0;
    int num_checks = 0;
    int lost_cnt = 0;
    int wr_cnt = 0;
    int prog_cnt = 0;
    sch_if link();
    sch_host u_sch_host (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_id(req_id),
        .req_frequency(req_frequency), .req_fraction(req_fraction), .req_config(req_config),
        .req_pointer(req_pointer), .req_trigger(req_trigger), .list_we(list_we), .list_addr(list_addr),
        .list_data(list_data), .list_length(list_length), .resp_valid(resp_valid), .resp_status(resp_status),
        .lock_lost(lock_lost), .synth_up(synth_up), .link(link));
    sch_device u_sch_device (.clk(clk), .rst(rst), .link(link), .radio_setup_done(setup_done),
        .implicit_program(impl_prog), .synth_powered_ok(powered_ok), .synth_lock(lock_in),
        .synth_analog_on(analog_on), .synth_running(running), .synth_tx_mode(tx_mode),
        .synth_ref_divider(ref_div), .synth_freq_int(freq_int), .synth_freq_frac(freq_frac),
        .synth_program_strobe(prog_strobe), .ovr_write(ovr_write), .ovr_write_data(wr_data));
    sch_sva u_sch_sva (.clk(clk), .rst(rst), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
        .cmd_id(link.cmd_id), .frequency(link.frequency), .synth_config_byte(link.synth_config_byte),
        .ovr_req(link.ovr_req), .ovr_valid(link.ovr_valid), .done(link.done), .status(link.status),
        .lock_lost_irq(link.lock_lost_irq));
    initial
    begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // pulses are counted mid-cycle, where they have settled
    always @(negedge clk)
    begin
        if (lock_lost === 1'b1)
            lost_cnt++;
        if (ovr_write === 1'b1)
            wr_cnt++;
        if (prog_strobe === 1'b1)
            prog_cnt++;
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    // offer one request, hold it until taken, then wait a bounded time for the answer
    task automatic cmd(input logic [15:0] id, input logic [15:0] f, input logic [15:0] fr, input logic [7:0] cf,
        input logic [31:0] p, input logic [3:0] exp);
        int n;
        @(negedge clk);
        req_id = id;
        req_frequency = f;
        req_fraction = fr;
        req_config = cf;
        req_pointer = p;
        req_valid = 1;
        while (req_ready !== 1'b1)
            @(negedge clk);
        @(negedge clk);
        req_valid = 0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 600)
        begin
            @(negedge clk);
            n++;
        end
        check("response", {1'b1, exp}, {resp_valid, resp_status});
    endtask : cmd
    // lock is held long enough to pass the two-flop synchroniser before it drops
    task automatic lock_cycle();
        lock_in = 1;
        repeat (8) @(negedge clk);
        lock_in = 0;
        repeat (8) @(negedge clk);
    endtask : lock_cycle
    initial
    begin
        rst = 1;
        {req_valid, req_trigger, list_we, setup_done, impl_prog, powered_ok, lock_in} = '0;
        {req_id, req_frequency, req_fraction, req_config, req_pointer} = '0;
        {list_addr, list_data, list_length} = '0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 0;
        cmd(CMD_PROGRAM, 16'h0960, 16'h0000, 8'h00, 0, ST_NO_SETUP);
        setup_done = 1;
        cmd(CMD_PROGRAM, 16'h0960, 16'h0000, 8'h00, 0, ST_NOT_POWERED);
        cmd(CMD_POWER_UP, 0, 0, 0, 0, ST_PROG_ERR);
        check("analog after failure", 0, analog_on);
        powered_ok = 1;
        cmd(CMD_POWER_UP, 0, 0, 0, 0, ST_DONE_OK);
        check("analog_on", 1, analog_on);
        check("synth up", 1, synth_up);
        foreach (ents[i])
        begin
            @(negedge clk);
            list_we = 1;
            list_addr = 6'(i);
            list_data = ents[i];
        end
        @(negedge clk);
        list_we = 0;
        list_length = 6'h03;
        cmd(CMD_POWER_UP, 0, 0, 0, 32'h0000_0001, ST_DONE_OK);
        check("override writes", 2, wr_cnt);
        check("override data", 31'h0000_0033, wr_data);
        list_length = 6'h00;
        cmd(CMD_POWER_UP, 0, 0, 0, 32'h0000_0001, ST_PARAM_ERR);
        check("no write from empty list", 2, wr_cnt);
        cmd(16'h0999, 0, 0, 0, 0, ST_PARAM_ERR);
        cmd(CMD_PROGRAM, 16'h0154, 16'h0000, 8'h00, 0, ST_PARAM_ERR);
        cmd(CMD_PROGRAM, 16'h0a01, 16'h0000, 8'h00, 0, ST_PARAM_ERR);
        cmd(CMD_PROGRAM, 16'h0960, 16'h0000, 8'h80, 0, ST_PARAM_ERR);
        cmd(CMD_PROGRAM, 16'h0a00, 16'h8000, 8'h0b, 0, ST_DONE_OK);
        check("freq", 32'h0a00_8000, {freq_int, freq_frac});
        check("tx and divider", 7'h45, {tx_mode, ref_div});
        cmd(CMD_PROGRAM, 16'h0155, 16'h0001, 8'h00, 0, ST_DONE_OK);
        check("rx and default", {1'b0, DEFAULT_DIVIDER}, {tx_mode, ref_div});
        check("program strobes", 2, prog_cnt);
        lock_cycle();
        check("lock lost", 1, lost_cnt);
        lock_cycle();
        check("lock lost once", 1, lost_cnt);
        impl_prog = 1;
        @(negedge clk);
        impl_prog = 0;
        lock_cycle();
        check("lock lost implicit", 2, lost_cnt);
        cmd(CMD_TURN_OFF, 0, 0, 0, 0, ST_DONE_OK);
        check("off state", 2'b01, {running, analog_on});
        fork
            cmd(CMD_POWER_DOWN, 0, 0, 0, 0, ST_DONE_OK);
            begin
                repeat (20) @(negedge clk);
                check("waits for trigger", 1, analog_on);
                req_trigger = 1;
            end
        join
        check("analog off", 0, analog_on);
        check("synth down", 0, synth_up);
        cmd(CMD_PROGRAM, 16'h0960, 16'h0000, 8'h00, 0, ST_NOT_POWERED);
        end_of_test();
    end
    // the sequence needs well under two thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
